// [rtl/srs_map.svh]
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
// ----------------------------------------
// register offsets (word index on the port)
// ----------------------------------------
`define SRS_A_CTRL 6'h00
`define SRS_A_RISE 6'h01
`define SRS_A_FALL 6'h02
`define SRS_A_UNIT 6'h03
`define SRS_A_STAT 6'h04
`define SRS_A_WSV 6'h05
`define SRS_A_ELAP 6'h06
`define SRS_A_SV 6'h10
`define SRS_A_DW 6'h18
`define SRS_A_LK 6'h20
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define SRS_C_RUN 0
`define SRS_C_RS 1
`define SRS_C_HRS 2
`define SRS_C_AT 3
`define SRS_CTRL_RST 3'h1
`define SRS_RATE_OFF 16'h0000
`define SRS_LINK_OFF 4'h0
`define SRS_LINK_MAX 4'h8
`define SRS_UNIT_MIN 12'h001
`define SRS_UNIT_MAX 12'he10
`define SRS_UNIT_RST 12'h001
`define SRS_MM_MAX 8'hc7
`define SRS_HH_MAX 8'h63
`define SRS_MINOR_MAX 8'h3b
`define SRS_PER_MIN 16'h003c
`define SRS_SPAN 16'h0578
// ----------------------------------------
// timing
// ----------------------------------------
`define SRS_CLK_HZ 20000000
`define SRS_TICK_S 1
`endif

// [rtl/srs_pkg.sv]
`default_nettype none
package srs_pkg;
  localparam int SRS_DW = 16;
  localparam int SRS_AREAS = 8;
  typedef logic [SRS_DW-1:0] srs_val_t;
  typedef enum logic [3:0] {
    ST_STOP = 4'b0001,
    ST_RAMP = 4'b0010,
    ST_SOAK = 4'b0100,
    ST_HOLD = 4'b1000
  } srs_state_t;
  typedef struct packed {
    logic [5:0] addr;
    srs_val_t wdata;
    logic wr;
    logic rd;
  } srs_bus_t;
endpackage : srs_pkg
`default_nettype wire

// [rtl/srs_tick.sv]
`include "srs_map.svh"
`default_nettype none
module srs_tick #(
  parameter int unsigned CYCLES = `SRS_CLK_HZ * `SRS_TICK_S
)
(
  input wire logic clk,
  input wire logic srst,
  output logic pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (srst || cnt_r == LAST)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pulse <= 1'b0;
    else
      pulse <= (cnt_r == LAST);
  end
endmodule : srs_tick
`default_nettype wire

// [rtl/srs_dwell.sv]
`include "srs_map.svh"
`default_nettype none
module srs_dwell
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sec_tick,
  input wire logic run,
  input wire logic hours,
  input wire srs_val_t dwell,
  output logic done,
  output srs_val_t elapsed
);
  logic [7:0] pre_r;
  srs_val_t elap_r;
  srs_val_t total;
  logic minor_tick;

  // dwell is major:minor, minor counts seconds or minutes
  assign total = {8'h00, dwell[15:8]} * `SRS_PER_MIN + {8'h00, dwell[7:0]};
  assign minor_tick = sec_tick && (!hours || pre_r == `SRS_MINOR_MAX);

  always_ff @(posedge clk)
  begin
    if (srst || !run || !hours)
      pre_r <= '0;
    else if (sec_tick)
      pre_r <= (pre_r == `SRS_MINOR_MAX) ? 8'h00 : pre_r + 8'h01;
  end

  // elapsed only runs while soaking; cleared otherwise
  always_ff @(posedge clk)
  begin
    if (srst || !run)
      elap_r <= '0;
    else if (minor_tick && !done)
      elap_r <= elap_r + 16'h0001;
  end

  // compared to the live value, so a rewrite counts from time spent
  assign done = run && elap_r >= total; // see R12
  assign elapsed = elap_r;
endmodule : srs_dwell
`default_nettype wire

// [rtl/srs_top.sv]
// Our own choices: the register addresses and the plain strobed port.
`include "srs_map.svh"
`default_nettype none
// Operation
// R1: raising the target ramps the working value up at the rise rate.
// R2: lowering the target ramps the working value down at the fall rate.
// R3: each rate is one count up to span per unit time, or off; off at reset.
// R4: unit time is whole seconds, one to three thousand six hundred.
// R5: with limiting on, ramp from measured value at power-on and stop-to-run.
// R6: auto tuning requested mid-ramp waits until the ramp ends.
// R7: a rate rewritten mid-ramp applies to the rest of the ramp.
// R8: any rate not off suppresses event re-hold on target change.
// R9: dwell is min:sec to 199:59 or hr:min to 99:59; zero at reset.
// R10: in ramp/soak mode, move to the linked area after the dwell.
// R11: dwell timing starts only once the ramp has reached its target.
// R12: a rewritten dwell leaves new dwell minus time already spent.
// R13: each area links to area one to eight, or off; off at reset.
// R14: last area of a chain ignores its dwell and holds its value; here it soaks out its dwell, then moves to hold.
// R15: each unit tick steps by the rate, clamped to the target.
module srs_top
  import srs_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SRS_CLK_HZ * `SRS_TICK_S,
  parameter srs_val_t SPAN = `SRS_SPAN
)
(
  input wire logic clk,
  input wire logic srst,
  input wire srs_bus_t bus,
  input wire srs_val_t pv,
  output srs_val_t rdata,
  output srs_val_t working_sv,
  output logic ramping,
  output logic soaking,
  output logic [2:0] area,
  output logic auto_tuning_start,
  output logic auto_tuning_pending,
  output logic event_rehold
);
  srs_val_t rise_r, fall_r, wsv_r, wsv_nxt, rdata_r, rd_val, tgt_q_r;
  srs_val_t target, rate, gap, step, elapsed;
  logic [11:0] unit_r, usec_r;
  logic [2:0] ctrl_r, cur_r, cur_nxt;
  logic [3:0] lk;
  srs_state_t state_r, state_nxt;
  srs_val_t sv_m [SRS_AREAS];
  srs_val_t dw_m [SRS_AREAS];
  logic [3:0] lk_m [SRS_AREAS];
  logic at_pend_r, at_start_r, rehold_r, at_set, at_go;
  logic sec_tick, unit_tick, dw_done, limiting, up, run;

  function automatic logic area_hit(input logic [5:0] a,
                                    input logic [5:0] base);
    return a[5:3] == base[5:3];
  endfunction : area_hit

  function automatic srs_val_t lim_rate(input srs_val_t v,
                                        input srs_val_t span);
    return (v > span) ? span : v;
  endfunction : lim_rate

  function automatic srs_val_t lim_dwell(input srs_val_t v,
                                         input logic hrs);
    logic [7:0] top;
    top = hrs ? `SRS_HH_MAX : `SRS_MM_MAX;
    return {(v[15:8] > top) ? top : v[15:8],
            (v[7:0] > `SRS_MINOR_MAX) ? `SRS_MINOR_MAX : v[7:0]};
  endfunction : lim_dwell

  // ----------------------------------------
  // tick sources
  // ----------------------------------------
  srs_tick #(
    .CYCLES(SEC_CYCLES)
  ) u_sec (
    .clk(clk),
    .srst(srst),
    .pulse(sec_tick)
  );

  srs_dwell u_dwell (
    .clk(clk),
    .srst(srst),
    .sec_tick(sec_tick),
    .run(state_r == ST_SOAK && ctrl_r[`SRS_C_RS]), // see R11
    .hours(ctrl_r[`SRS_C_HRS]),
    .dwell(dw_m[cur_r]),
    .done(dw_done),
    .elapsed(elapsed)
  );

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r <= `SRS_CTRL_RST;
      rise_r <= `SRS_RATE_OFF; // see R3
      fall_r <= `SRS_RATE_OFF;
      unit_r <= `SRS_UNIT_RST;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        `SRS_A_CTRL: ctrl_r <= bus.wdata[2:0];
        `SRS_A_RISE: rise_r <= lim_rate(bus.wdata, SPAN); // see R3
        `SRS_A_FALL: fall_r <= lim_rate(bus.wdata, SPAN);
        `SRS_A_UNIT:
        begin
          if (bus.wdata < {4'h0, `SRS_UNIT_MIN})
            unit_r <= `SRS_UNIT_MIN; // see R4
          else if (bus.wdata > {4'h0, `SRS_UNIT_MAX})
            unit_r <= `SRS_UNIT_MAX;
          else
            unit_r <= bus.wdata[11:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // memory areas
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < SRS_AREAS; i++)
      begin
        sv_m[i] <= '0;
        dw_m[i] <= '0; // see R9
        lk_m[i] <= `SRS_LINK_OFF; // see R13
      end
    end
    else if (bus.wr)
    begin
      if (area_hit(bus.addr, `SRS_A_SV))
        sv_m[bus.addr[2:0]] <= bus.wdata;
      if (area_hit(bus.addr, `SRS_A_DW))
        dw_m[bus.addr[2:0]] <= lim_dwell(bus.wdata, ctrl_r[`SRS_C_HRS]);
      if (area_hit(bus.addr, `SRS_A_LK))
        lk_m[bus.addr[2:0]] <= (bus.wdata > {12'h000, `SRS_LINK_MAX}) ?
                               `SRS_LINK_OFF : bus.wdata[3:0]; // see R13
    end
  end

  // ----------------------------------------
  // ramp arithmetic
  // ----------------------------------------
  assign run = ctrl_r[`SRS_C_RUN];
  assign target = sv_m[cur_r];
  assign lk = lk_m[cur_r];
  assign limiting = rise_r != `SRS_RATE_OFF || fall_r != `SRS_RATE_OFF;
  assign unit_tick = state_r == ST_RAMP && sec_tick &&
                     usec_r >= unit_r - `SRS_UNIT_MIN; // see R4

  always_ff @(posedge clk)
  begin
    if (srst || state_r != ST_RAMP || unit_tick)
      usec_r <= '0;
    else if (sec_tick)
      usec_r <= usec_r + 12'h001;
  end

  // live rate registers, so a rewrite steers the remaining ramp
  always_comb
  begin
    up = target > wsv_r;
    rate = up ? rise_r : fall_r; // see R1 R2 R7
    gap = up ? target - wsv_r : wsv_r - target;
    if (rate == `SRS_RATE_OFF || gap <= rate)
      step = target; // see R15
    else if (up)
      step = wsv_r + rate;
    else
      step = wsv_r - rate;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    wsv_nxt = wsv_r;
    case (state_r)
      ST_STOP:
        if (run)
        begin
          wsv_nxt = limiting ? pv : target; // see R5
          state_nxt = ST_RAMP;
        end
      ST_RAMP:
      begin
        if (rate == `SRS_RATE_OFF || unit_tick)
          wsv_nxt = step; // see R1 R2 R15
        if (wsv_r == target)
          state_nxt = ST_SOAK;
      end
      ST_SOAK:
        if (wsv_r != target)
          state_nxt = ST_RAMP;
        else if (dw_done && lk == `SRS_LINK_OFF)
          state_nxt = ST_HOLD; // see R14
        else if (dw_done)
        begin
          cur_nxt = 3'(lk - 4'h1); // see R10
          state_nxt = ST_RAMP;
        end
      ST_HOLD:
        if (wsv_r != target)
          state_nxt = ST_RAMP;
      default: state_nxt = ST_STOP;
    endcase
    if (!run)
      state_nxt = ST_STOP;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ST_STOP;
      cur_r <= '0;
      wsv_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      wsv_r <= wsv_nxt;
    end
  end

  // ----------------------------------------
  // auto tuning deferral and event re-hold
  // ----------------------------------------
  assign at_set = bus.wr && bus.addr == `SRS_A_CTRL && bus.wdata[`SRS_C_AT];
  assign at_go = at_pend_r && (state_r == ST_SOAK || state_r == ST_HOLD);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      at_pend_r <= 1'b0;
      at_start_r <= 1'b0;
    end
    else
    begin
      at_pend_r <= at_set || (at_pend_r && !at_go); // see R6
      at_start_r <= at_go;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tgt_q_r <= '0;
      rehold_r <= 1'b0;
    end
    else
    begin
      tgt_q_r <= target;
      rehold_r <= !limiting && state_r != ST_STOP &&
                  target != tgt_q_r; // see R8
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb
  begin
    rd_val = '0;
    case (bus.addr)
      `SRS_A_CTRL: rd_val = {13'h0000, ctrl_r};
      `SRS_A_RISE: rd_val = rise_r;
      `SRS_A_FALL: rd_val = fall_r;
      `SRS_A_UNIT: rd_val = {4'h0, unit_r};
      `SRS_A_STAT: rd_val = {8'h00, at_pend_r, state_r, cur_r};
      `SRS_A_WSV: rd_val = wsv_r;
      `SRS_A_ELAP: rd_val = elapsed;
      default: ;
    endcase
    if (area_hit(bus.addr, `SRS_A_SV))
      rd_val = sv_m[bus.addr[2:0]];
    if (area_hit(bus.addr, `SRS_A_DW))
      rd_val = dw_m[bus.addr[2:0]];
    if (area_hit(bus.addr, `SRS_A_LK))
      rd_val = {12'h000, lk_m[bus.addr[2:0]]};
  end

  always_ff @(posedge clk)
  begin
    if (srst || !bus.rd)
      rdata_r <= '0;
    else
      rdata_r <= rd_val;
  end

  assign rdata = rdata_r;
  assign working_sv = wsv_r;
  assign ramping = state_r == ST_RAMP;
  assign soaking = state_r == ST_SOAK && ctrl_r[`SRS_C_RS];
  assign area = cur_r;
  assign auto_tuning_start = at_start_r;
  assign auto_tuning_pending = at_pend_r;
  assign event_rehold = rehold_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_rise_step: assert property ( // see R1
    state_r == ST_RAMP && unit_tick && up && rise_r != 0 && gap > rise_r
    |=> wsv_r == $past(wsv_r) + $past(rise_r))
    else $error("rise step wrong");
  chk_fall_step: assert property ( // see R2
    state_r == ST_RAMP && unit_tick && !up && fall_r != 0 && gap > fall_r
    |=> wsv_r == $past(wsv_r) - $past(fall_r))
    else $error("fall step wrong");
  chk_clamp_target: assert property ( // see R15
    state_r == ST_RAMP && (unit_tick || rate == 0) && gap <= rate
    |=> wsv_r == $past(target))
    else $error("ramp passed target");
  chk_wait_unit: assert property ( // see R4
    state_r == ST_RAMP && !unit_tick && rate != 0 |=> $stable(wsv_r))
    else $error("step off unit tick");
  chk_unit_range: assert property ( // see R4
    unit_r >= `SRS_UNIT_MIN && unit_r <= `SRS_UNIT_MAX)
    else $error("unit time out of range");
  chk_off_reset: assert property ( // see R3
    $fell(srst) |-> rise_r == 0 && fall_r == 0 && rate <= SPAN)
    else $error("rate not off after reset");
  chk_start_ramp: assert property ( // see R5
    state_r == ST_STOP && run && limiting
    |=> state_r == ST_RAMP && wsv_r == $past(pv))
    else $error("no ramp from measured value");
  chk_at_defer: assert property ( // see R6
    auto_tuning_start |-> $past(at_pend_r) && $past(state_r) != ST_RAMP)
    else $error("tuning started during ramp");
  chk_rehold_off: assert property ( // see R8
    event_rehold |-> !$past(limiting))
    else $error("re-hold while limiting");
  chk_soak_clear: assert property ( // see R11
    state_r != ST_SOAK |=> elapsed == 0)
    else $error("dwell counted outside soak");
  chk_link_jump: assert property ( // see R10
    state_r == ST_SOAK && wsv_r == target && dw_done && lk != 0 && run
    |=> state_r == ST_RAMP && cur_r == 3'($past(lk) - 4'h1))
    else $error("link transfer wrong");
  chk_last_hold: assert property ( // see R14
    state_r == ST_SOAK && wsv_r == target && dw_done && lk == 0 && run
    |=> state_r == ST_HOLD ##1 $stable(cur_r))
    else $error("last area did not hold");
  chk_dwell_fmt: assert property ( // see R9
    dw_m[cur_r][7:0] <= `SRS_MINOR_MAX)
    else $error("dwell minor field over range");

  cov_ramp_soak: cover property (state_r == ST_RAMP ##1 state_r == ST_SOAK);
  cov_link: cover property (state_r == ST_SOAK && dw_done && lk != 0);
  cov_at_defer: cover property (at_pend_r && ramping ##[1:50] at_start_r);
endmodule : srs_top
`default_nettype wire

// [tb/setpoint_ramp_soak_tb.sv]
`include "srs_map.svh"
`default_nettype none
module setpoint_ramp_soak_tb
  import srs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  srs_bus_t bus = '0;
  srs_val_t pv = '0;
  srs_val_t rdata;
  srs_val_t working_sv;
  logic ramping;
  logic soaking;
  logic [2:0] area;
  logic auto_tuning_start;
  logic auto_tuning_pending;
  logic event_rehold;
  int errors = 0;
  int n_checks = 0;
  int n_rh = 0;
  int n;
  srs_val_t v;
  // ----------------------------------------
  // register table: address, write flag, data, expected read
  // ----------------------------------------
  logic [5:0] t_a [0:10] = '{6'h01, 6'h02, 6'h03, 6'h18, 6'h20, 6'h3f,
    6'h01, 6'h03, 6'h03, 6'h20, 6'h18};
  logic t_w [0:10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1};
  srs_val_t t_d [0:10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h1234, 16'hffff, 16'h0000, 16'h1000, 16'h0009, 16'hc83c};
  srs_val_t t_e [0:10] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000,
    16'h0000, 16'h0000, `SRS_SPAN, 16'h0001, 16'h0e10, 16'h0000, 16'hc73b};

  always #25 clk = ~clk;

  srs_top #(
    .SEC_CYCLES(4)
  )
  srs_top_i (
    .clk(clk),
    .srst(srst),
    .bus(bus),
    .pv(pv),
    .rdata(rdata),
    .working_sv(working_sv),
    .ramping(ramping),
    .soaking(soaking),
    .area(area),
    .auto_tuning_start(auto_tuning_start),
    .auto_tuning_pending(auto_tuning_pending),
    .event_rehold(event_rehold)
  );

  always @(posedge clk)
    if (event_rehold === 1'b1)
      n_rh <= n_rh + 1;

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic check(input string name, input srs_val_t seen,
    input srs_val_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input srs_val_t d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output srs_val_t d);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask : rd

  // waits for the next change of working_sv, or for a given value
  task automatic step(input srs_val_t exp, input bit change);
    srs_val_t old;
    int i;
    old = working_sv;
    for (i = 0; i < 200; i++)
    begin
      if (change ? working_sv !== old : working_sv === exp)
        break;
      @(posedge clk);
      #1;
    end
    check("working_sv", working_sv, exp);
  endtask : step

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    #(4000 * 50);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++)
    begin
      if (t_w[i])
        wr(t_a[i], t_d[i]);
      rd(t_a[i], v);
      check("register", v, t_e[i]);
    end
    wr(`SRS_A_CTRL, 16'h0005);
    wr(`SRS_A_DW, 16'h6400);
    rd(`SRS_A_DW, v);
    check("dwell hr:min", v, 16'h6300);
    wr(`SRS_A_CTRL, 16'h0001);
    wr(`SRS_A_DW, 16'h0000);
    wr(`SRS_A_UNIT, 16'h0001);
    $display("test 1 done");
    wr(`SRS_A_RISE, 16'h000a);
    wr(`SRS_A_FALL, 16'h0005);
    wr(`SRS_A_SV, 16'h0019);
    step(16'h000a, 1);
    step(16'h0014, 1);
    step(16'h0019, 1);
    $display("test 2 done");
    wr(`SRS_A_SV, 16'h000c);
    step(16'h0014, 1);
    wr(`SRS_A_FALL, 16'h0008);
    step(16'h000c, 1);
    $display("test 3 done");
    wr(`SRS_A_SV, 16'h0028);
    step(16'h0016, 1);
    wr(`SRS_A_CTRL, 16'h0009);
    @(posedge clk);
    #1;
    check("pending", {15'h0, auto_tuning_pending}, 16'h0001);
    check("ramping", {15'h0, ramping}, 16'h0001);
    rd(`SRS_A_STAT, v);
    check("status", v, 16'h0090);
    check("start early", {15'h0, auto_tuning_start}, 16'h0000);
    for (n = 0; n < 200 && auto_tuning_start !== 1'b1; n++)
      @(posedge clk) #1;
    check("start", {15'h0, auto_tuning_start}, 16'h0001);
    check("ramp over", working_sv, 16'h0028);
    check("ramp ended", {15'h0, ramping}, 16'h0000);
    $display("test 4 done");
    check("rehold with limit", 16'(n_rh), 16'h0000);
    wr(`SRS_A_RISE, 16'h0000);
    wr(`SRS_A_FALL, 16'h0000);
    wr(`SRS_A_SV, 16'h0029);
    step(16'h0029, 1);
    repeat (2) @(posedge clk);
    check("rehold no limit", 16'(n_rh), 16'h0001);
    $display("test 5 done");
    wr(`SRS_A_RISE, 16'h000a);
    wr(`SRS_A_DW, 16'h0100);
    wr(`SRS_A_LK, 16'h0002);
    wr(`SRS_A_SV + 6'h01, 16'h003d);
    wr(`SRS_A_CTRL, 16'h0003);
    repeat (12) @(posedge clk);
    #1;
    check("soaking", {15'h0, soaking}, 16'h0001);
    check("dwell running", {13'h0, area}, 16'h0000);
    rd(`SRS_A_ELAP, v);
    check("elapsed", {15'h0, v >= 16'h0002}, 16'h0001);
    wr(`SRS_A_DW, 16'h0002);
    for (n = 0; n < 200 && area !== 3'h1; n++)
      @(posedge clk) #1;
    check("area linked", {13'h0, area}, 16'h0001);
    check("dwell rewrite", {15'h0, n <= 2}, 16'h0001);
    check("no soak in ramp", {15'h0, soaking}, 16'h0000);
    step(16'h0033, 1);
    step(16'h003d, 1);
    repeat (40) @(posedge clk);
    #1;
    check("last area", {13'h0, area}, 16'h0001);
    check("held value", working_sv, 16'h003d);
    $display("test 6 done");
    wr(`SRS_A_CTRL, 16'h0000);
    pv <= 16'h0064;
    wr(`SRS_A_FALL, 16'h0008);
    wr(`SRS_A_UNIT, 16'h0002);
    wr(`SRS_A_SV + 6'h01, 16'h001e);
    wr(`SRS_A_CTRL, 16'h0001);
    step(16'h0064, 0);
    step(16'h005c, 1);
    for (n = 0; n < 200 && working_sv === 16'h005c; n++)
      @(posedge clk) #1;
    check("unit spacing", 16'(n), 16'h0008);
    rd(`SRS_A_WSV, v);
    check("wsv register", v, 16'h0054);
    $display("test 7 done");
    end_sim();
  end
endmodule : setpoint_ramp_soak_tb
`default_nettype wire
